/* rtl/tbg_gateway.sv */
// sync gateway: counts sync requests per selector and releases all waiters
// assumes: thread ends on the same clk_sys; participant totals loaded by the
// user-side config port before requests arrive
`timescale 1ns/10ps
`default_nettype none
module tbg_gateway #(
  parameter int         TW  = 3,
  parameter logic [3:0] FID = 4'h7
) (
  input  wire logic          clk_sys,
  input  wire logic          sys_rst,
  input  wire logic          ce,
  input  wire logic          cfg_we,
  input  wire logic [3:0]    cfg_sel,
  input  wire logic [TW:0]   cfg_total,
  output logic               busy,
  tbg_link_if.gw             link
);
  import tbg_pkg::*;

  localparam int NT = 1 << TW;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [0:0] {
    TBG_IDLE,
    TBG_REL
  } tbg_st_t;

  typedef struct packed {
    tbg_st_t                        st;
    logic [TBG_NUM_SYNC-1:0][TW:0]  total;
    logic [TBG_NUM_SYNC-1:0][TW:0]  cnt;
    logic [TBG_NUM_SYNC-1:0][NT-1:0] pend;
    logic [NT-1:0][7:0]             loc;
    logic [3:0]                     sel;
    logic [TW-1:0]                  idx;
    logic [7:0]                     rbyte;
    logic                           wb_valid;
    logic [TW-1:0]                  wb_thread;
    logic [7:0]                     wb_reg;
    logic [31:0]                    wb_dword0;
    logic [31:0]                    wb_be;
    logic                           wb_n0;
  } tbg_gw_t;

  tbg_gw_t    q, d;
  logic       take;
  logic       free;
  logic [3:0] s;
  logic [TW:0] next_cnt;
  logic       act;

  // location of the release byte in the thread's register file
  function automatic logic [7:0] tbg_loc(input logic       bypass,
                                         input logic [7:0] base,
                                         input logic [7:0] off);
    logic [7:0] b;
    b = bypass ? 8'h00 : base;
    return 8'(b + {off[7:1], 1'b0});
  endfunction : tbg_loc

  // ****************************************************************
  // writeback words
  // ****************************************************************
  // a total of zero marks a state inactive: answered, never counted
  function automatic logic tbg_active(input logic [TW:0] total);
    return total != '0;
  endfunction : tbg_active

  function automatic logic [31:0] tbg_ack_word(input logic active);
    logic [31:0] w;
    w                   = '0;
    w[TBG_FID_LSB +: 4] = FID;
    w[TBG_ERR_W-1:0]    = active ? TBG_ERR_OK : TBG_ERR_INACT;
    return w;
  endfunction : tbg_ack_word

  // upper bytes stay zero; the byte enable keeps them out of the register anyway
  function automatic logic [31:0] tbg_rel_word(input logic [7:0] rbyte);
    return {24'h000000, rbyte};
  endfunction : tbg_rel_word

  // ****************************************************************
  // link handshake
  // ****************************************************************
  // requests wait while a writeback is held or a release sweep runs;
  // this serialises the sweep against new arrivals on the same state
  assign free     = !q.wb_valid || link.wb_ready;
  assign take     = link.req_valid && link.req_ready;
  assign s        = link.req_payload[TBG_SEL_LSB +: TBG_SEL_W];
  assign next_cnt = (TW+1)'(q.cnt[s] + 1'b1);
  assign act      = tbg_active(q.total[s]);

  assign link.req_ready        = ce && q.st == TBG_IDLE && !q.wb_valid;
  assign link.wb_valid         = q.wb_valid;
  assign link.wb_thread        = q.wb_thread;
  assign link.wb_reg           = q.wb_reg;
  assign link.wb_dword0        = q.wb_dword0;
  assign link.wb_byte_en       = q.wb_be;
  assign link.notify_flag_zero = q.wb_n0;
  assign busy                  = q.st != TBG_IDLE || q.wb_valid;

  // ****************************************************************
  // counting and release
  // ****************************************************************
  always_comb
  begin
    d = q;
    if (q.wb_valid && link.wb_ready)
      d.wb_valid = 1'b0;
    if (cfg_we)
      d.total[cfg_sel] = cfg_total;
    case (q.st)
      TBG_IDLE:
      begin
        if (take)
        begin
          if (link.req_ack_request)
          begin
            d.wb_valid  = 1'b1;
            d.wb_thread = link.req_thread;
            d.wb_reg    = link.req_ack_reg;
            d.wb_dword0 = tbg_ack_word(act);
            d.wb_be     = TBG_BE_ACK;
            d.wb_n0     = 1'b0;
          end
          if (act)
          begin
            d.cnt[s]                  = next_cnt;
            d.pend[s][link.req_thread] = 1'b1;
            d.loc[link.req_thread]    = tbg_loc(link.req_base_bypass, link.req_reg_base,
                                                link.req_payload[TBG_OFF_LSB +: TBG_OFF_W]);
            if (next_cnt == q.total[s])
            begin
              d.st    = TBG_REL;
              d.sel   = s;
              d.idx   = '0;
              d.rbyte = link.req_count_override ? 8'h00 : link.req_release_byte;
            end
          end
        end
      end
      TBG_REL:
      begin
        // one thread looked at per free cycle; non-waiters cost a cycle each
        if (free)
        begin
          if (q.pend[q.sel][q.idx])
          begin
            d.wb_valid  = 1'b1;
            d.wb_thread = q.idx;
            d.wb_reg    = q.loc[q.idx];
            d.wb_dword0 = tbg_rel_word(q.rbyte);
            d.wb_be     = TBG_BE_RELEASE;
            d.wb_n0     = 1'b1;
          end
          d.idx = TW'(q.idx + 1'b1);
          if (q.idx == TW'(NT - 1))
          begin
            d.cnt[q.sel]  = '0;
            d.pend[q.sel] = '0;
            d.st          = TBG_IDLE;
          end
        end
      end
      default:
        d.st = TBG_IDLE;
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    // reset does not wait for ce, so a frozen gateway can still be cleared
    if (sys_rst)
      q <= '0;
    else if (ce)
      q <= d;
  end

endmodule : tbg_gateway
`default_nettype wire

/* rtl/tbg_pkg.sv */
// constants shared by the sync gateway, its thread end and the link interface
// assumes: one common clock and reset for both ends
package tbg_pkg;

  // ****************************************************************
  // message layout
  // ****************************************************************
  localparam int          TBG_PAYLOAD_W   = 256;
  localparam int          TBG_NUM_SYNC    = 16;
  localparam int          TBG_SEL_W       = 4;
  localparam int          TBG_SEL_LSB     = 88;
  localparam int          TBG_OFF_W       = 8;
  localparam int          TBG_OFF_LSB     = 80;
  localparam int          TBG_FID_LSB     = 16;
  localparam int          TBG_ERR_W       = 3;
  localparam logic [2:0]  TBG_ERR_OK      = 3'h0;
  localparam logic [2:0]  TBG_ERR_INACT   = 3'h1;
  localparam logic [31:0] TBG_BE_ACK      = 32'h0000_000f;
  localparam logic [31:0] TBG_BE_RELEASE  = 32'h0000_0001;

  // ****************************************************************
  // thread end register map (byte addresses)
  // ****************************************************************
  localparam logic [3:0]  TBG_A_CTRL      = 4'h0;
  localparam logic [3:0]  TBG_A_BASE      = 4'h4;
  localparam logic [3:0]  TBG_A_STAT      = 4'h8;
  localparam int          TBG_C_SEND      = 0;
  localparam int          TBG_C_SEL_LSB   = 4;
  localparam int          TBG_C_OFF_LSB   = 8;
  localparam int          TBG_C_ACK       = 16;
  localparam int          TBG_C_BYPASS    = 17;
  localparam int          TBG_C_OVERRIDE  = 18;
  localparam int          TBG_B_BASE_LSB  = 0;
  localparam int          TBG_B_BYTE_LSB  = 8;
  localparam int          TBG_B_ACKR_LSB  = 16;
  localparam int          TBG_S_PEND      = 0;
  localparam int          TBG_S_REL       = 1;
  localparam int          TBG_S_ACK       = 2;
  localparam int          TBG_S_ERR_LSB   = 4;
  localparam int          TBG_S_BYTE_LSB  = 8;
  localparam int          TBG_S_REG_LSB   = 16;

endpackage : tbg_pkg

/* rtl/tbg_link_if.sv */
// link between execution threads and the sync gateway
// assumes: both ends on clk_sys; the bench joins one thread end to it
`timescale 1ns/10ps
`default_nettype none
interface tbg_link_if #(
  parameter int TW = 3
);
  logic                             req_valid;
  logic                             req_ready;
  logic [tbg_pkg::TBG_PAYLOAD_W-1:0] req_payload;
  logic [TW-1:0]                    req_thread;
  logic                             req_ack_request;
  logic                             req_base_bypass;
  logic                             req_count_override;
  logic [7:0]                       req_reg_base;
  logic [7:0]                       req_release_byte;
  logic [7:0]                       req_ack_reg;
  logic                             wb_valid;
  logic                             wb_ready;
  logic [TW-1:0]                    wb_thread;
  logic [7:0]                       wb_reg;
  logic [31:0]                      wb_dword0;
  logic [31:0]                      wb_byte_en;
  logic                             notify_flag_zero;

  modport gw (
    input  req_valid, req_payload, req_thread, req_ack_request, req_base_bypass,
    input  req_count_override, req_reg_base, req_release_byte, req_ack_reg, wb_ready,
    output req_ready, wb_valid, wb_thread, wb_reg, wb_dword0, wb_byte_en, notify_flag_zero
  );
  modport thr (
    output req_valid, req_payload, req_thread, req_ack_request, req_base_bypass,
    output req_count_override, req_reg_base, req_release_byte, req_ack_reg, wb_ready,
    input  req_ready, wb_valid, wb_thread, wb_reg, wb_dword0, wb_byte_en, notify_flag_zero
  );
endinterface : tbg_link_if
`default_nettype wire

/* rtl/tbg_thread.sv */
// thread end: software builds one sync request over avalon-mm and sees answers
// assumes: a gateway on the same clk_sys; one thread end per thread number
`timescale 1ns/10ps
`default_nettype none
module tbg_thread #(
  parameter int          TW  = 3,
  parameter logic [2:0]  TID = 3'h0
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  tbg_link_if.thr          link
);
  import tbg_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic        pend;
    logic [3:0]  sel;
    logic [7:0]  off;
    logic        ack;
    logic        bypass;
    logic        override;
    logic [7:0]  base;
    logic [7:0]  rbyte;
    logic [7:0]  ack_reg;
    logic        released;
    logic        acked;
    logic [2:0]  err;
    logic [7:0]  last_byte;
    logic [7:0]  last_reg;
    logic        rd_done;
    logic [31:0] rdata;
  } tbg_thr_t;

  tbg_thr_t q, d;
  logic     wr_ok;
  logic     wb_mine;

  // a send while one is still outstanding stalls the master, never drops
  assign avs_waitrequest = !ce || (avs_write && avs_address == TBG_A_CTRL && q.pend)
                           || (avs_read && !q.rd_done);
  assign wr_ok   = avs_write && !avs_waitrequest;
  assign wb_mine = link.wb_valid && link.wb_ready && link.wb_thread == TW'(TID);

  // ****************************************************************
  // link drive
  // ****************************************************************
  always_comb
  begin
    link.req_payload = '0;
    link.req_payload[TBG_SEL_LSB +: TBG_SEL_W] = q.sel;
    link.req_payload[TBG_OFF_LSB +: TBG_OFF_W] = {1'b0, q.off[6:1], 1'b0};
  end
  assign link.req_valid          = q.pend;
  assign link.req_thread         = TW'(TID);
  assign link.req_ack_request    = q.ack;
  assign link.req_base_bypass    = q.bypass;
  assign link.req_count_override = q.override;
  assign link.req_reg_base       = q.base;
  assign link.req_release_byte   = q.rbyte;
  assign link.req_ack_reg        = q.ack_reg;
  assign link.wb_ready           = ce;
  assign avs_readdata            = q.rdata;

  // ****************************************************************
  // registers and answers
  // ****************************************************************
  always_comb
  begin
    d = q;
    d.rd_done = avs_read && !q.rd_done;
    if (avs_read && !q.rd_done)
    begin
      d.rdata = '0;
      if (avs_address == TBG_A_CTRL)
      begin
        d.rdata[TBG_C_SEL_LSB +: 4] = q.sel;
        d.rdata[TBG_C_OFF_LSB +: 8] = q.off;
        d.rdata[TBG_C_ACK]          = q.ack;
        d.rdata[TBG_C_BYPASS]       = q.bypass;
        d.rdata[TBG_C_OVERRIDE]     = q.override;
      end
      else if (avs_address == TBG_A_BASE)
        d.rdata = {8'h00, q.ack_reg, q.rbyte, q.base};
      else if (avs_address == TBG_A_STAT)
      begin
        d.rdata[TBG_S_PEND]          = q.pend;
        d.rdata[TBG_S_REL]           = q.released;
        d.rdata[TBG_S_ACK]           = q.acked;
        d.rdata[TBG_S_ERR_LSB +: 3]  = q.err;
        d.rdata[TBG_S_BYTE_LSB +: 8] = q.last_byte;
        d.rdata[TBG_S_REG_LSB +: 8]  = q.last_reg;
      end
    end
    if (link.req_valid && link.req_ready)
      d.pend = 1'b0;
    if (wr_ok && avs_address == TBG_A_CTRL)
    begin
      d.sel      = avs_writedata[TBG_C_SEL_LSB +: 4];
      d.off      = avs_writedata[TBG_C_OFF_LSB +: 8];
      d.ack      = avs_writedata[TBG_C_ACK];
      d.bypass   = avs_writedata[TBG_C_BYPASS];
      d.override = avs_writedata[TBG_C_OVERRIDE];
      d.pend     = avs_writedata[TBG_C_SEND];
    end
    else if (wr_ok && avs_address == TBG_A_BASE)
    begin
      d.base    = avs_writedata[TBG_B_BASE_LSB +: 8];
      d.rbyte   = avs_writedata[TBG_B_BYTE_LSB +: 8];
      d.ack_reg = avs_writedata[TBG_B_ACKR_LSB +: 8];
    end
    else if (wr_ok && avs_address == TBG_A_STAT)
    begin
      if (avs_writedata[TBG_S_REL])
        d.released = 1'b0;
      if (avs_writedata[TBG_S_ACK])
        d.acked = 1'b0;
    end
    // set after clear so a same-cycle answer is not lost
    if (wb_mine && link.notify_flag_zero)
    begin
      d.released  = 1'b1;
      d.last_byte = link.wb_dword0[7:0];
      d.last_reg  = link.wb_reg;
    end
    else if (wb_mine)
    begin
      d.acked = 1'b1;
      d.err   = link.wb_dword0[2:0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      q <= '0;
    else if (ce)
      q <= d;
  end

endmodule : tbg_thread
`default_nettype wire

/* testbench/tbg_properties.sv */
// checker: watches the link between one thread end and the sync gateway
// assumes: a single thread end on the link, so the last taken request completes a release
`timescale 1ns/10ps
`default_nettype none
module tbg_properties #(
  parameter logic [3:0] FID = 4'h7
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         req_valid,
  input  wire logic         req_ready,
  input  wire logic [255:0] req_payload,
  input  wire logic         req_ack_request,
  input  wire logic         req_base_bypass,
  input  wire logic         req_count_override,
  input  wire logic [7:0]   req_reg_base,
  input  wire logic [7:0]   req_release_byte,
  input  wire logic         wb_valid,
  input  wire logic         wb_ready,
  input  wire logic [7:0]   wb_reg,
  input  wire logic [31:0]  wb_dword0,
  input  wire logic [31:0]  wb_byte_en,
  input  wire logic         notify_flag_zero,
  input  wire logic         busy
);
  import tbg_pkg::*;
  // ****************************************************************
  // expected release target, taken from the last accepted request
  // ****************************************************************
  logic [7:0] exp_reg_q;
  logic [7:0] exp_byte_q;
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      exp_reg_q  <= 8'h00;
      exp_byte_q <= 8'h00;
    end
    else if (req_valid && req_ready)
    begin
      exp_reg_q  <= (req_base_bypass ? 8'h00 : req_reg_base)
                    + (req_payload[TBG_OFF_LSB +: 8] & 8'hfe);
      exp_byte_q <= req_count_override ? 8'h00 : req_release_byte;
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_rel_bytes: assert property (wb_valid && notify_flag_zero |-> wb_byte_en == 32'h0000_0001)
    else $error("release enables more than one byte");
  a_rel_upper: assert property (wb_valid && notify_flag_zero |-> wb_dword0[31:8] == 24'h0)
    else $error("release carries data above the byte");
  a_rel_reg: assert property (wb_valid && notify_flag_zero |-> wb_reg == exp_reg_q)
    else $error("release register wrong");
  a_rel_byte: assert property (wb_valid && notify_flag_zero |-> wb_dword0[7:0] == exp_byte_q)
    else $error("release byte wrong");
  a_ack_bytes: assert property (wb_valid && !notify_flag_zero |-> wb_byte_en == 32'h0000_000f)
    else $error("ack enables beyond dword zero");
  a_ack_fid: assert property (wb_valid && !notify_flag_zero
    |-> wb_dword0[19:16] == FID && wb_dword0[31:20] == 12'h0)
    else $error("ack function identifier wrong");
  a_ack_code: assert property (wb_valid && !notify_flag_zero
    |-> wb_dword0[15:0] inside {16'h0000, 16'h0001})
    else $error("ack code field wrong");
  a_ack_sent: assert property (req_valid && req_ready && req_ack_request
    |=> wb_valid && !notify_flag_zero)
    else $error("ack missing");
  a_ack_none: assert property (req_valid && req_ready && !req_ack_request
    |=> !(wb_valid && !notify_flag_zero))
    else $error("ack without request");
  a_wb_hold: assert property (wb_valid && !wb_ready
    |=> wb_valid && $stable(wb_dword0) && $stable(wb_reg))
    else $error("writeback dropped before taken");
  a_sweep_ends: assert property ($rose(busy) |-> ##[1:40] !busy)
    else $error("gateway stays busy");
endmodule : tbg_properties
`default_nettype wire

/* testbench/tb_thread_barrier_gateway.sv */
// testbench: one thread end and the gateway joined by the link, model in the bench
// assumes: gateway with TW 3, thread end number 2, totals loaded through the cfg port
`timescale 1ns/10ps
`default_nettype none
module tb_thread_barrier_gateway;
  import tbg_pkg::*;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        ce = 1'b1;
  logic        cfg_we = 1'b0;
  logic [3:0]  cfg_sel = 4'h0;
  logic [3:0]  cfg_total = 4'h0;
  logic        busy;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] st;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cnt[16];
  int          tot[16];
  logic        ce_jitter = 1'b0;
  always #25 clk_sys = ~clk_sys;
  // ce drops at random only while ce_jitter is set, so cfg loads are never frozen out
  always @(posedge clk_sys)
    ce <= ce_jitter ? (($urandom % 4) != 0) : 1'b1;
  tbg_link_if link ();
  tbg_gateway #(.TW(3), .FID(4'h5)) tbg_gateway_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .ce(ce), .cfg_we(cfg_we), .cfg_sel(cfg_sel), .cfg_total(cfg_total), .busy(busy),
    .link(link.gw));
  tbg_thread #(.TID(3'h2)) tbg_thread_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .ce(ce), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(link.thr));
  tbg_properties #(.FID(4'h5)) tbg_properties_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .req_valid(link.req_valid), .req_ready(link.req_ready), .req_payload(link.req_payload),
    .req_ack_request(link.req_ack_request), .req_base_bypass(link.req_base_bypass),
    .req_count_override(link.req_count_override), .req_reg_base(link.req_reg_base),
    .req_release_byte(link.req_release_byte), .wb_valid(link.wb_valid),
    .wb_ready(link.wb_ready), .wb_reg(link.wb_reg), .wb_dword0(link.wb_dword0),
    .wb_byte_en(link.wb_byte_en), .notify_flag_zero(link.notify_flag_zero), .busy(busy));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      num_errors++;
    end
  endtask : check
  // bus cycle: request held until an edge samples waitrequest low
  task bus(input logic [3:0] a, input logic wr, input logic [31:0] d, output logic [31:0] rd);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do
    begin
      @(posedge clk_sys);
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus
  task load_total(input logic [3:0] sel, input logic [3:0] total);
    @(posedge clk_sys);
    cfg_sel   <= sel;
    cfg_total <= total;
    cfg_we    <= 1'b1;
    @(posedge clk_sys);
    cfg_we    <= 1'b0;
    tot[sel] = int'(total);
  endtask : load_total
  task sync_send(input logic [3:0] sel, input logic [7:0] off, input logic ack, input logic byp,
                 input logic ovr);
    logic [7:0]  base;
    logic [7:0]  rbyte;
    logic [7:0]  ereg;
    logic [2:0]  eerr;
    logic [31:0] d;
    logic        rel;
    int          n;
    base  = 8'($urandom);
    rbyte = 8'($urandom);
    bus(TBG_A_STAT, 1'b1, 32'h0000_0006, d);
    bus(TBG_A_BASE, 1'b1, {8'h00, 8'($urandom), rbyte, base}, d);
    bus(TBG_A_CTRL, 1'b1, {13'h0, ovr, byp, ack, off, sel, 4'h1}, d);
    n = 0;
    do
    begin
      bus(TBG_A_STAT, 1'b0, 32'h0, st);
      n++;
    end
    while (st[TBG_S_PEND] !== 1'b0 && n < 50);
    check({31'h0, st[TBG_S_PEND]}, 32'h0);
    n = 0;
    while (busy !== 1'b0 && n < 100)
    begin
      @(posedge clk_sys);
      n++;
    end
    check({31'h0, busy}, 32'h0);
    // model: count per selector, release and clear when the total is met
    rel  = 1'b0;
    eerr = (tot[sel] == 0) ? TBG_ERR_INACT : TBG_ERR_OK;
    if (tot[sel] != 0)
    begin
      cnt[sel]++;
      rel = (cnt[sel] == tot[sel]);
      if (rel)
        cnt[sel] = 0;
    end
    ereg = (byp ? 8'h00 : base) + (off & 8'h7e);
    bus(TBG_A_STAT, 1'b0, 32'h0, st);
    check({31'h0, st[TBG_S_REL]}, {31'h0, rel});
    check({31'h0, st[TBG_S_ACK]}, {31'h0, ack});
    if (ack)
      check({29'h0, st[TBG_S_ERR_LSB +: 3]}, {29'h0, eerr});
    if (rel)
      check({24'h0, st[TBG_S_BYTE_LSB +: 8]}, {24'h0, ovr ? 8'h00 : rbyte});
    if (rel)
      check({24'h0, st[TBG_S_REG_LSB +: 8]}, {24'h0, ereg});
  endtask : sync_send
  task conclude();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude
  // ****************************************************************
  // sequence
  // ****************************************************************
  initial
  begin
    #1000000;
    num_errors++;
    conclude();
  end
  initial
  begin
    for (int i = 0; i < 16; i++)
    begin
      cnt[i] = 0;
      tot[i] = 0;
    end
    void'($urandom(32'hfb72));
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    load_total(4'h3, 4'h2);
    load_total(4'h5, 4'h1);
    sync_send(4'h3, 8'h04, 1'b1, 1'b0, 1'b0);
    sync_send(4'h3, 8'h07, 1'b0, 1'b0, 1'b0);
    sync_send(4'h3, 8'h7e, 1'b1, 1'b1, 1'b1);
    sync_send(4'h3, 8'h21, 1'b1, 1'b1, 1'b0);
    sync_send(4'h9, 8'h02, 1'b1, 1'b0, 1'b0);
    // mid-run reset: totals and counters clear, so selector 3 now reads inactive
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      cnt[i] = 0;
      tot[i] = 0;
    end
    sync_send(4'h3, 8'h02, 1'b1, 1'b0, 1'b0);
    load_total(4'h5, 4'h1);
    // random parameters on a one-member selector, so each send releases; ce stutters
    ce_jitter <= 1'b1;
    for (int i = 0; i < 8; i++)
      sync_send(4'h5, 8'($urandom % 128), 1'($urandom), 1'($urandom), 1'($urandom));
    ce_jitter <= 1'b0;
    bus(4'hc, 1'b0, 32'h0, st);
    check(st, 32'h0);
    conclude();
  end
endmodule : tb_thread_barrier_gateway
`default_nettype wire
